// File: logic/rts_cfg.svh
// Constants of the render target select and sample operations block
`ifndef RTS_CFG_SVH
`define RTS_CFG_SVH
`define RTS_NUM_OUT 4
`define RTS_NUM_SMP 4
`define RTS_SMP_LOG 2
`define RTS_CH_W 8
`define RTS_ADR_CTRL 8'h00
`define RTS_ADR_CMD 8'h04
`define RTS_ADR_STATUS 8'h08
`define RTS_ADR_MASK_ALL 8'h0c
`define RTS_ADR_LIST 8'h10
`define RTS_ADR_TARGET 8'h20
`define RTS_ADR_CHMASK 8'h30
`define RTS_CTRL_OFFSCREEN 0
`define RTS_CTRL_WINDOW 1
`define RTS_CTRL_DOUBLE 2
`define RTS_CTRL_MSAA 3
`define RTS_CTRL_ATT_LSB 4
`define RTS_CTRL_RESET 8'h02
`define RTS_ERR_VALUE 0
`define RTS_ERR_ENUM 1
`define RTS_ERR_OP 2
`define RTS_TGT_EMPTY 4'h0
`define RTS_TGT_BACK 4'h1
`define RTS_TGT_FRONT 4'h2
`define RTS_TGT_ATT_BASE 4'h8
`define RTS_MASK_RESET 4'hf
`endif

// File: logic/rts_pkg.sv
// Types of the render target select and sample operations block
`include "rts_cfg.svh"
package rts_pkg;
   typedef logic [3:0] rts_tgt_t;
   typedef logic [4*`RTS_CH_W-1:0] rts_col_t;
   typedef struct packed {
      logic [`RTS_NUM_SMP-1:0] cov;
      logic [`RTS_NUM_SMP-1:0] pass;
      rts_col_t [`RTS_NUM_OUT-1:0] colour;
      rts_col_t [`RTS_NUM_SMP-1:0] dst_smp;
   } rts_frag_t;
   typedef struct packed {
      logic [`RTS_NUM_OUT-1:0] wr;
      rts_tgt_t [`RTS_NUM_OUT-1:0] tgt;
      rts_col_t [`RTS_NUM_OUT-1:0] data;
      logic [`RTS_NUM_OUT-1:0][3:0] chan;
      logic [`RTS_NUM_SMP-1:0] smp;
   } rts_store_t;
   typedef struct packed {
      logic [`RTS_NUM_SMP-1:0] wr;
      rts_col_t [`RTS_NUM_SMP-1:0] data;
   } rts_ms_t;
endpackage

// File: logic/rts_top.sv
// Render target selection, channel masking and per-sample store logic
//
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "rts_cfg.svh"
module rts_top #(
   parameter int NUM_OUT = `RTS_NUM_OUT,
   parameter int NUM_SMP = `RTS_NUM_SMP
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Fragments from shading
   input wire logic frag_valid_i,
   input wire rts_pkg::rts_frag_t frag_i,
   output logic frag_ready_o,
   // Framebuffer stores
   output rts_pkg::rts_store_t store_o,
   output rts_pkg::rts_ms_t ms_o
);
   import rts_pkg::*;

   logic [7:0] ctrl;
   logic [2:0] err;
   rts_tgt_t list [NUM_OUT];
   rts_tgt_t sel [NUM_OUT];
   logic [3:0] chmask [NUM_OUT];
   logic ack;
   logic wr_acc;
   logic rd_acc;
   logic ctrl_wr;
   logic cmd_wr;
   logic [2:0] cmd_err;
   rts_tgt_t cmd_sel [NUM_OUT];

   function automatic logic is_att(input rts_tgt_t t);
      return t[3] == 1'b1 && int'(t[2:0]) < NUM_OUT;
   endfunction

   function automatic logic known(input rts_tgt_t t);
      return t == `RTS_TGT_EMPTY || t == `RTS_TGT_BACK || is_att(t);
   endfunction

   // Register hit for word o of a bank starting at base
   function automatic logic adr_hit(input logic [7:0] a, input logic [7:0] base, input int o);
      return a == base + 8'(4 * o);
   endfunction

   // Initial selection for a given binding
   function automatic rts_tgt_t init_sel(input int o, input logic [7:0] c);
      if (o != 0) begin
         return `RTS_TGT_EMPTY;
      end
      if (c[`RTS_CTRL_OFFSCREEN]) begin
         return `RTS_TGT_ATT_BASE;
      end
      return c[`RTS_CTRL_WINDOW] ? `RTS_TGT_BACK : `RTS_TGT_EMPTY;
   endfunction

   // Wishbone handshake: ack one cycle after the request, then drop
   assign wb_ack_o = ack;
   assign wr_acc = wb_cyc_i & wb_stb_i & wb_we_i & ~ack & wb_sel_i[0];
   assign rd_acc = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack;
   assign ctrl_wr = wr_acc && wb_adr_i == `RTS_ADR_CTRL;
   assign cmd_wr = wr_acc && wb_adr_i == `RTS_ADR_CMD;

   // Register decode, one write strobe per register
   logic status_wr;
   logic mask_all_wr;
   logic [NUM_OUT-1:0] list_wr;
   logic [NUM_OUT-1:0] chmask_wr;

   always_comb begin
      status_wr = wr_acc && adr_hit(wb_adr_i, `RTS_ADR_STATUS, 0);
      mask_all_wr = wr_acc && adr_hit(wb_adr_i, `RTS_ADR_MASK_ALL, 0);
      for (int o = 0; o < NUM_OUT; o++) begin
         list_wr[o] = wr_acc && adr_hit(wb_adr_i, `RTS_ADR_LIST, o);
         chmask_wr[o] = wr_acc && adr_hit(wb_adr_i, `RTS_ADR_CHMASK, o);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack <= 1'b0;
      end else begin
         ack <= wb_cyc_i & wb_stb_i & ~ack;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0;
      end else if (rd_acc) begin
         wb_dat_o <= 32'h0;
         if (wb_adr_i == `RTS_ADR_CTRL) begin
            wb_dat_o <= {24'h0, ctrl};
         end else if (wb_adr_i == `RTS_ADR_STATUS) begin
            wb_dat_o <= {29'h0, err};
         end
         for (int o = 0; o < NUM_OUT; o++) begin
            if (adr_hit(wb_adr_i, `RTS_ADR_LIST, o)) begin
               wb_dat_o <= {28'h0, list[o]};
            end
            if (adr_hit(wb_adr_i, `RTS_ADR_TARGET, o)) begin
               wb_dat_o <= {28'h0, sel[o]};
            end
            if (adr_hit(wb_adr_i, `RTS_ADR_CHMASK, o)) begin
               wb_dat_o <= {28'h0, chmask[o]};
            end
         end
      end
   end

   // Binding and surface configuration
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= `RTS_CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl <= wb_dat_i[7:0];
      end
   end

   // Staged target list
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int o = 0; o < NUM_OUT; o++) begin
            list[o] <= `RTS_TGT_EMPTY;
         end
      end else begin
         for (int o = 0; o < NUM_OUT; o++) begin
            if (list_wr[o]) begin
               list[o] <= wb_dat_i[3:0];
            end
         end
      end
   end

   // Check a selection command against the list and binding
   always_comb begin
      logic signed [7:0] n;
      n = signed'(wb_dat_i[7:0]);
      cmd_err = 3'h0;
      for (int o = 0; o < NUM_OUT; o++) begin
         cmd_sel[o] = (o < int'(n)) ? list[o] : `RTS_TGT_EMPTY;
      end
      if (n < 0 || int'(n) > NUM_OUT) begin
         cmd_err[`RTS_ERR_VALUE] = 1'b1;
      end else begin
         for (int o = 0; o < NUM_OUT; o++) begin
            if (o < int'(n) && !known(list[o])) begin
               cmd_err[`RTS_ERR_ENUM] = 1'b1;
            end
         end
         if (cmd_err == 3'h0) begin
            if (!ctrl[`RTS_CTRL_OFFSCREEN]) begin
               if (int'(n) != 1 ||
                   (list[0] != `RTS_TGT_BACK && list[0] != `RTS_TGT_EMPTY)) begin
                  cmd_err[`RTS_ERR_OP] = 1'b1;
               end
            end else begin
               for (int o = 0; o < NUM_OUT; o++) begin
                  if (o < int'(n) && list[o] != `RTS_TGT_EMPTY &&
                      list[o] != (`RTS_TGT_ATT_BASE | 4'(o))) begin
                     cmd_err[`RTS_ERR_OP] = 1'b1;
                  end
               end
            end
         end
      end
   end

   // Current selection; a rebinding restores that binding's initial state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int o = 0; o < NUM_OUT; o++) begin
            sel[o] <= init_sel(o, `RTS_CTRL_RESET);
         end
      end else if (ctrl_wr) begin
         for (int o = 0; o < NUM_OUT; o++) begin
            sel[o] <= init_sel(o, wb_dat_i[7:0]);
         end
      end else if (cmd_wr && cmd_err == 3'h0) begin
         for (int o = 0; o < NUM_OUT; o++) begin
            sel[o] <= cmd_sel[o];
         end
      end
   end

   // Sticky error flags, write one to clear, a new error wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         err <= 3'h0;
      end else begin
         err <= (err & ~(status_wr ? wb_dat_i[2:0] : 3'h0))
                | (cmd_wr ? cmd_err : 3'h0);
      end
   end

   // Channel write masks
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int o = 0; o < NUM_OUT; o++) begin
            chmask[o] <= `RTS_MASK_RESET;
         end
      end else begin
         for (int o = 0; o < NUM_OUT; o++) begin
            if (mask_all_wr) begin
               chmask[o] <= wb_dat_i[3:0];
            end else if (chmask_wr[o]) begin
               chmask[o] <= wb_dat_i[3:0];
            end
         end
      end
   end

   // Fragment path, one fragment per cycle, never stalls
   assign frag_ready_o = 1'b1;

   logic msaa;
   logic [NUM_SMP-1:0] live;
   rts_col_t new_smp [NUM_SMP];
   rts_col_t merged;
   rts_store_t next_store;
   rts_ms_t next_ms;

   assign msaa = ctrl[`RTS_CTRL_MSAA];
   // Only covered samples that passed stencil and depth go on
   assign live = frag_i.cov & frag_i.pass;

   always_comb begin
      logic [`RTS_CH_W+`RTS_SMP_LOG-1:0] acc;
      acc = '0;
      merged = '0;
      for (int s = 0; s < NUM_SMP; s++) begin
         new_smp[s] = live[s] ? frag_i.colour[0] : frag_i.dst_smp[s];
      end
      for (int c = 0; c < 4; c++) begin
         acc = '0;
         for (int s = 0; s < NUM_SMP; s++) begin
            acc = acc + (`RTS_CH_W+`RTS_SMP_LOG)'(new_smp[s][c*`RTS_CH_W +: `RTS_CH_W]);
         end
         merged[c*`RTS_CH_W +: `RTS_CH_W] = acc[`RTS_CH_W+`RTS_SMP_LOG-1:`RTS_SMP_LOG];
      end
   end

   always_comb begin
      next_store = '0;
      next_ms = '0;
      if (frag_valid_i && sel[0] != `RTS_TGT_EMPTY) begin
         for (int o = 0; o < NUM_OUT; o++) begin
            next_store.tgt[o] = sel[o];
            next_store.chan[o] = chmask[o];
            next_store.data[o] = frag_i.colour[o];
            if (sel[o] == `RTS_TGT_EMPTY) begin
               next_store.wr[o] = 1'b0;
            end else if (is_att(sel[o])) begin
               next_store.wr[o] = ctrl[`RTS_CTRL_ATT_LSB + int'(sel[o][2:0])];
            end else begin
               // Back maps to the sole or the back surface
               next_store.tgt[o] = ctrl[`RTS_CTRL_DOUBLE] ?
                                   `RTS_TGT_BACK : `RTS_TGT_FRONT;
               next_store.wr[o] = 1'b1;
            end
         end
         if (msaa) begin
            next_store.smp = live;
            if (!ctrl[`RTS_CTRL_OFFSCREEN]) begin
               for (int s = 0; s < NUM_SMP; s++) begin
                  next_ms.wr[s] = live[s];
                  next_ms.data[s] = new_smp[s];
               end
               next_store.data[0] = merged;
               next_store.wr = next_store.wr & {NUM_OUT{|live}};
            end else begin
               next_store.wr = next_store.wr & {NUM_OUT{|live}};
            end
         end else begin
            next_store.smp = {NUM_SMP{1'b1}};
            next_store.wr = next_store.wr & {NUM_OUT{live[0]}};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         store_o <= '0;
         ms_o <= '0;
      end else begin
         store_o <= next_store;
         ms_o <= next_ms;
      end
   end
endmodule

// File: dv/rts_fb_model.sv
// Framebuffer store model behind the final colour stores
`timescale 1ns/10ps
`include "rts_cfg.svh"
module rts_fb_model
   import rts_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Final stores
   input wire rts_pkg::rts_store_t store_i
);
   rts_col_t mem [`RTS_NUM_OUT];
   // Masked channels keep their old bytes
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < `RTS_NUM_OUT; i++) begin
         for (int c = 0; c < 4; c++) begin
            if (store_i.wr[i] && store_i.chan[i][c]) begin
               mem[i][c*8+:8] <= store_i.data[i][c*8+:8];
            end
         end
      end
   end
endmodule

// File: dv/rts_top_assertions.sv
// Port checker of the render target select block
`timescale 1ns/10ps
`include "rts_cfg.svh"
module rts_top_checker
   import rts_pkg::*;
#(
   parameter int NUM_OUT = 4,
   parameter int NUM_SMP = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic frag_valid_i,
   input wire rts_pkg::rts_frag_t frag_i,
   input wire logic frag_ready_o,
   input wire rts_pkg::rts_store_t store_o,
   input wire rts_pkg::rts_ms_t ms_o
);
   logic [NUM_OUT-1:0] tgt_empty;
   always_comb begin
      for (int i = 0; i < NUM_OUT; i++) begin
         tgt_empty[i] = store_o.tgt[i] == `RTS_TGT_EMPTY;
      end
   end
   logic [7:0] ctrl_sh;
   // Shadow of the control register, to know the sampling mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_sh <= `RTS_CTRL_RESET;
      end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] &&
                   wb_adr_i == `RTS_ADR_CTRL) begin
         ctrl_sh <= wb_dat_i[7:0];
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_one_shot_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   ack_answers_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   ack_has_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
      else $error("ack without request");
   ready_high_a: assert property (frag_ready_o) else $error("ready low");
   store_needs_frag_a: assert property (|store_o.wr |-> $past(frag_valid_i))
      else $error("store without fragment");
   empty_no_write_a: assert property (!(|(store_o.wr & tgt_empty)))
      else $error("write to empty target");
   sample_covered_a: assert property ((ms_o.wr & ~$past(frag_i.cov)) == '0)
      else $error("uncovered sample written");
   sample_passed_a: assert property ((ms_o.wr & ~$past(frag_i.pass)) == '0)
      else $error("failed sample written");
   store_smp_live_a: assert property (
      |store_o.wr && $past(ctrl_sh[`RTS_CTRL_MSAA]) |->
      (store_o.smp & ~$past(frag_i.cov & frag_i.pass)) == '0)
      else $error("dead sample enabled");
   store_smp_whole_a: assert property (
      |store_o.wr && !$past(ctrl_sh[`RTS_CTRL_MSAA]) |->
      store_o.smp == '1 && $past(frag_i.cov[0] && frag_i.pass[0]))
      else $error("single sample store wrong");
   ms_one_cycle_a: assert property (!$past(frag_valid_i) |-> ms_o.wr == '0)
      else $error("sample write without fragment");
endmodule
bind rts_top rts_top_checker #(.NUM_OUT(NUM_OUT), .NUM_SMP(NUM_SMP)) u_chk (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o),
   .frag_valid_i(frag_valid_i),
   .frag_i(frag_i),
   .frag_ready_o(frag_ready_o),
   .store_o(store_o),
   .ms_o(ms_o)
);

// File: dv/rts_top_test.sv
// Self-checking bench of the render target select block
`timescale 1ns/10ps
`include "rts_cfg.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
   $display("wrong value %s exp %h got %h", n, e, g); end end
module rts_top_test;
   import rts_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, fv = 0, ack, rdy;
   logic [7:0] adr = '0;
   logic [31:0] dat = '0, rdat, d;
   logic [3:0] sel = 4'hf, nsel = 4'hf;
   rts_frag_t frag = '0;
   rts_store_t st;
   rts_ms_t ms;
   int err_count = 0, tests_run = 0;
   always #4 clk_i = ~clk_i;
   rts_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .frag_valid_i(fv), .frag_i(frag), .frag_ready_o(rdy), .store_o(st), .ms_o(ms));
   rts_fb_model u_fb (.clk_i(clk_i), .store_i(st));
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
      int n = 0;
      @(posedge clk_i);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dat <= v;
      sel <= nsel;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      d = rdat;
      cyc <= 0;
      stb <= 0;
      if (n >= 20) `CHK("ack", 1'b1, 1'b0)
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      wb(0, a, 0);
      `CHK("reg", e, d)
   endtask
   task automatic fr(input logic [3:0] cv, input logic [3:0] ps, input rts_col_t c);
      @(posedge clk_i);
      fv <= 1;
      frag <= '{cov: cv, pass: ps, colour: {4{c}}, dst_smp: '0};
      @(posedge clk_i);
      fv <= 0;
      @(posedge clk_i);
   endtask
   task automatic t_reset;
      rc(8'h20, 1);
      rc(8'h24, 0);
      rc(8'h30, 4'hf);
      rc(8'h3c, 4'hf);
      rc(8'h00, 2);
      rc(8'hfc, 0);
   endtask
   task automatic t_errors;
      logic [7:0] n [4] = '{8'h02, 8'hff, 8'h05, 8'h01};
      logic [2:0] s [4] = '{3'h4, 3'h1, 3'h1, 3'h2};
      for (int i = 0; i < 4; i++) begin
         wb(1, 8'h10, i == 3 ? 3 : 1);
         wb(1, 8'h04, n[i]);
         rc(8'h08, s[i]);
         wb(1, 8'h08, 7);
      end
      rc(8'h08, 0);
      rc(8'h20, 1);
   endtask
   task automatic t_window;
      wb(1, 8'h10, 0);
      wb(1, 8'h04, 1);
      rc(8'h20, 0);
      fr(4'hf, 4'hf, 32'h44332211);
      `CHK("wr", 4'h0, st.wr)
      `CHK("ms", 4'h0, ms.wr)
      for (int i = 0; i < 2; i++) begin
         wb(1, 8'h00, i ? 6 : 2);
         fr(1, 1, 32'h44332211);
         `CHK("tgt", i ? 4'h1 : 4'h2, st.tgt[0])
         `CHK("wr0", 1'b1, st.wr[0])
      end
   endtask
   task automatic t_mask;
      wb(1, 8'h0c, 5);
      rc(8'h3c, 5);
      nsel = 4'he;
      wb(1, 8'h0c, 0);
      nsel = 4'hf;
      rc(8'h3c, 5);
      wb(1, 8'h34, 2);
      rc(8'h30, 5);
      rc(8'h34, 2);
      fr(1, 1, 32'h88776655);
      `CHK("chan", 4'h5, st.chan[0])
      @(posedge clk_i);
      `CHK("mem", 32'h44772255, u_fb.mem[0])
   endtask
   task automatic t_off;
      wb(1, 8'h00, 8'h31);
      rc(8'h20, 8);
      wb(1, 8'h10, 8);
      wb(1, 8'h14, 9);
      wb(1, 8'h04, 2);
      rc(8'h24, 9);
      rc(8'h28, 0);
      wb(1, 8'h14, 8);
      wb(1, 8'h04, 2);
      rc(8'h08, 4);
      rc(8'h24, 9);
      wb(1, 8'h08, 7);
      wb(1, 8'h14, 0);
      wb(1, 8'h18, 8'h0a);
      wb(1, 8'h04, 3);
      fr(1, 1, 32'h1);
      `CHK("wr", 4'h1, st.wr)
      fr(1, 0, 32'h1);
      `CHK("wr", 4'h0, st.wr)
      wb(1, 8'h04, 0);
      rc(8'h20, 0);
   endtask
   task automatic t_msaa;
      wb(1, 8'h00, 8'h0a);
      fr(4'hb, 4'hd, 32'h40404040);
      `CHK("ms", 4'h9, ms.wr)
      `CHK("smp", 4'h9, st.smp)
      `CHK("ms0", 32'h40404040, ms.data[0])
      `CHK("avg", 32'h20202020, st.data[0])
      wb(1, 8'h00, 8'h19);
      fr(4'hb, 4'hd, 32'h40404040);
      `CHK("wr", 4'h1, st.wr)
      `CHK("ms", 4'h0, ms.wr)
      `CHK("smp", 4'h9, st.smp)
      `CHK("att", 32'h40404040, st.data[0])
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #200000;
      err_count++;
      summarize;
   end
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 0;
      t_reset;
      t_errors;
      t_window;
      t_mask;
      t_off;
      t_msaa;
      summarize;
   end
endmodule
